// ===== src/exec_slice_pkg.sv
// Constants, register map and encodings of the execution slice.
// Assumes one APB master and a single 250 MHz processor clock.
`default_nettype none

package exec_slice_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 8;
	localparam logic [ADDR_W-1:0] CMD_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] FIELD_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] SRC1_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] SRC2_OFS = 8'h0c;
	localparam logic [ADDR_W-1:0] DST_OFS = 8'h10;
	localparam logic [ADDR_W-1:0] RESULT_OFS = 8'h14;
	localparam logic [ADDR_W-1:0] FLAGS_OFS = 8'h18;
	localparam logic [ADDR_W-1:0] PC_OFS = 8'h1c;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h20;
	// Command word fields
	localparam int unsigned OP_LSB = 0;
	localparam int unsigned COND_LSB = 8;
	// Field word: offset in [4:0], width in [13:8]
	localparam int unsigned FOFS_LSB = 0;
	localparam int unsigned FWID_LSB = 8;
	// Condition indicator bits
	localparam int unsigned FLAG_N = 3;
	localparam int unsigned FLAG_Z = 2;
	localparam int unsigned FLAG_V = 1;
	localparam int unsigned FLAG_C = 0;
	// Status bits
	localparam int unsigned ST_BUSY = 0;
	localparam int unsigned ST_DIVZ = 1;
	localparam int unsigned ST_TAKEN = 2;
	localparam logic [4:0] DIV_LAST = 5'h1f;
	localparam logic [5:0] FULL_WIDTH = 6'h20;

	typedef enum logic [3:0] {
		op_none = 4'h0,
		divide_byte_three_operand = 4'h1,
		divide_half_three_operand = 4'h2,
		divide_word_three_operand = 4'h3,
		op_extract = 4'h4,
		op_insert = 4'h5,
		op_jump = 4'h6,
		op_branch = 4'h7
	} op_type;

	typedef enum logic [3:0] {
		jump_if_zero = 4'h0, cc_nonzero = 4'h1, cc_pos = 4'h2,
		cc_npos = 4'h3, cc_neg = 4'h4, cc_nneg = 4'h5,
		jump_if_equal = 4'h6, cc_ne = 4'h7,
		jump_if_less = 4'h8, cc_le = 4'h9,
		jump_if_greater = 4'ha, cc_ge = 4'hb,
		cc_ltu = 4'hc, cc_leu = 4'hd, cc_gtu = 4'he, cc_geu = 4'hf
	} cond_type;

	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_div = 3'b010,
		st_done = 3'b100
	} state_type;
endpackage : exec_slice_pkg

`default_nettype wire

// ===== src/exec_slice.sv
// Divide, bit-field and conditional jump slice behind an APB slave.
// Assumes a well-behaved APB master; one transfer at a time.
//
// The implementer's own choices: the register addresses and register access over APB.
`default_nettype none

module exec_slice (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [exec_slice_pkg::ADDR_W-1:0] paddr,
	input wire logic [exec_slice_pkg::DATA_W-1:0] pwdata,
	output logic [exec_slice_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr
);
	import exec_slice_pkg::*;

	function automatic logic [31:0] low_mask(input logic [5:0] w);
		low_mask = (w >= FULL_WIDTH) ? 32'hffffffff
			: ((32'h1 << w) - 32'h1);
	endfunction : low_mask

	function automatic logic [31:0] width_mask(input op_type op);
		unique case (op)
			divide_byte_three_operand: width_mask = 32'h000000ff;
			divide_half_three_operand: width_mask = 32'h0000ffff;
			default: width_mask = 32'hffffffff;
		endcase
	endfunction : width_mask

	function automatic logic [31:0] sign_ext(input logic [31:0] v,
			input op_type op);
		unique case (op)
			divide_byte_three_operand: sign_ext = {{24{v[7]}}, v[7:0]};
			divide_half_three_operand: sign_ext = {{16{v[15]}}, v[15:0]};
			default: sign_ext = v;
		endcase
	endfunction : sign_ext

	function automatic logic [31:0] mag(input logic [31:0] v);
		mag = v[31] ? (32'h0 - v) : v;
	endfunction : mag

	logic [31:0] src1_q, src2_q, dst_q, result_q, pc_q;
	logic [31:0] field_q;
	logic [3:0] flags_q;
	logic divz_q, taken_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q;
	state_type state_q;
	logic [4:0] cnt_q;
	logic [31:0] quo_q, div_b_q, wmask_q;
	logic [32:0] rem_q;
	logic neg_q;
	logic [31:0] rd_mux;

	// Bus decode
	wire setup = psel && !penable;
	wire acc = psel && penable && pready_q && !pslverr_q;
	wire wr_acc = acc && pwrite;
	wire busy = (state_q != st_idle);
	wire op_type op_w = op_type'(pwdata[OP_LSB +: 4]);
	wire cond_type cond_w = cond_type'(pwdata[COND_LSB +: 4]);
	wire op_ok = (op_w != op_none) && (pwdata[OP_LSB+3] == 1'b0);
	wire addr_rw = (paddr == CMD_OFS) || (paddr == FIELD_OFS)
		|| (paddr == SRC1_OFS) || (paddr == SRC2_OFS)
		|| (paddr == DST_OFS) || (paddr == FLAGS_OFS)
		|| (paddr == PC_OFS) || (paddr == STATUS_OFS);
	wire addr_ok = addr_rw || ((paddr == RESULT_OFS) && !pwrite);
	// A new command while dividing is refused, never queued
	wire cmd_bad = pwrite && (paddr == CMD_OFS) && (busy || !op_ok);
	wire go = wr_acc && (paddr == CMD_OFS);
	wire [4:0] f_ofs = field_q[FOFS_LSB +: 5];
	wire [5:0] f_wid = field_q[FWID_LSB +: 6];
	wire [31:0] lmask = low_mask(f_wid);
	wire [31:0] fmask = lmask << f_ofs;

	// Field operations
	wire [31:0] extract_val = (src2_q >> f_ofs) & lmask;
	wire [31:0] insert_val = (dst_q & ~fmask)
		| ((src2_q & lmask) << f_ofs);

	// Condition tests, compare-style indicators
	wire fn = flags_q[FLAG_N];
	wire fz = flags_q[FLAG_Z];
	wire fv = flags_q[FLAG_V];
	wire fc = flags_q[FLAG_C];
	wire lt_s = fn ^ fv;
	logic cond_hit;
	always_comb begin
		unique case (cond_w)
			jump_if_zero, jump_if_equal: cond_hit = fz;
			cc_nonzero, cc_ne: cond_hit = !fz;
			cc_pos: cond_hit = !fn && !fz;
			cc_npos: cond_hit = fn || fz;
			cc_neg: cond_hit = fn;
			cc_nneg: cond_hit = !fn;
			jump_if_less: cond_hit = lt_s;
			cc_le: cond_hit = lt_s || fz;
			jump_if_greater: cond_hit = !lt_s && !fz;
			cc_ge: cond_hit = !lt_s;
			cc_ltu: cond_hit = fc;
			cc_leu: cond_hit = fc || fz;
			cc_gtu: cond_hit = !fc && !fz;
			cc_geu: cond_hit = !fc;
		endcase
	end
	wire [31:0] br_disp = {{23{dst_q[7]}}, dst_q[7:0], 1'b0};

	// Divide set-up and restoring step
	wire [31:0] dvd_s = sign_ext(src2_q, op_w);
	wire [31:0] dvs_s = sign_ext(src1_q, op_w);
	wire is_div = (op_w == divide_byte_three_operand)
		|| (op_w == divide_half_three_operand)
		|| (op_w == divide_word_three_operand);
	wire div_go = go && is_div && (dvs_s != 32'h0);
	wire div_zero = go && is_div && (dvs_s == 32'h0);
	wire [32:0] rem_sh = {rem_q[31:0], quo_q[31]};
	wire [32:0] rem_diff = rem_sh - {1'b0, div_b_q};
	wire rem_ge = !rem_diff[32];
	wire [31:0] quo_s = neg_q ? (32'h0 - quo_q) : quo_q;
	wire [31:0] quo_w = quo_s & wmask_q;
	wire quo_neg = |(quo_w & ~(wmask_q >> 1));
	wire div_fin = (state_q == st_done);

	// Bus answer: ready in every access phase, read data from setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup && (!addr_ok || cmd_bad);
			prdata_q <= (setup && !pwrite) ? rd_mux : 32'h0;
		end
	end

	always_comb begin
		unique case (paddr)
			CMD_OFS: rd_mux = 32'h0;
			FIELD_OFS: rd_mux = field_q;
			SRC1_OFS: rd_mux = src1_q;
			SRC2_OFS: rd_mux = src2_q;
			DST_OFS: rd_mux = dst_q;
			RESULT_OFS: rd_mux = result_q;
			FLAGS_OFS: rd_mux = {28'h0, flags_q};
			PC_OFS: rd_mux = pc_q;
			STATUS_OFS: rd_mux = {29'h0, taken_q, divz_q, busy};
			default: rd_mux = 32'h0;
		endcase
	end

	// Operand registers; the divide never writes them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src1_q <= 32'h0;
			src2_q <= 32'h0;
			dst_q <= 32'h0;
			field_q <= 32'h0;
		end else if (wr_acc) begin
			if (paddr == SRC1_OFS) src1_q <= pwdata;
			if (paddr == SRC2_OFS) src2_q <= pwdata;
			if (paddr == DST_OFS) dst_q <= pwdata;
			if (paddr == FIELD_OFS) field_q <= pwdata & 32'h00003f1f;
		end
	end

	// Result, indicators and pc; jumps leave indicators alone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_q <= 32'h0;
			flags_q <= 4'h0;
			pc_q <= 32'h0;
			taken_q <= 1'b0;
		end else begin
			if (div_fin) begin
				result_q <= (dst_q & ~wmask_q) | quo_w;
				flags_q <= {quo_neg, quo_w == 32'h0, 2'b00};
			end else if (go && op_w == op_extract) begin
				result_q <= extract_val;
			end else if (go && op_w == op_insert) begin
				result_q <= insert_val;
			end else if (wr_acc && paddr == FLAGS_OFS) begin
				flags_q <= pwdata[3:0];
			end
			if (go && op_w == op_jump && cond_hit) begin
				pc_q <= dst_q;
			end else if (go && op_w == op_branch && cond_hit) begin
				pc_q <= pc_q + br_disp;
			end else if (wr_acc && paddr == PC_OFS) begin
				pc_q <= pwdata;
			end
			if (go && (op_w == op_jump || op_w == op_branch)) begin
				taken_q <= cond_hit;
			end
		end
	end

	// Divide-by-zero is sticky; a new event beats a write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			divz_q <= 1'b0;
		end else if (div_zero) begin
			divz_q <= 1'b1;
		end else if (wr_acc && paddr == STATUS_OFS && pwdata[ST_DIVZ]) begin
			divz_q <= 1'b0;
		end
	end

	// Iterative divider, one quotient bit per cycle for area
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= st_idle;
			cnt_q <= 5'h0;
			quo_q <= 32'h0;
			rem_q <= 33'h0;
			div_b_q <= 32'h0;
			wmask_q <= 32'h0;
			neg_q <= 1'b0;
		end else begin
			unique case (state_q)
				st_idle: if (div_go) begin
					state_q <= st_div;
					cnt_q <= DIV_LAST;
					quo_q <= mag(dvd_s);
					rem_q <= 33'h0;
					div_b_q <= mag(dvs_s);
					wmask_q <= width_mask(op_w);
					neg_q <= dvd_s[31] ^ dvs_s[31];
				end
				st_div: begin
					rem_q <= rem_ge ? rem_diff : rem_sh;
					quo_q <= {quo_q[30:0], rem_ge};
					cnt_q <= cnt_q - 5'h1;
					if (cnt_q == 5'h0) state_q <= st_done;
				end
				st_done: state_q <= st_idle;
			endcase
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	div_latency_a: assert property (div_go |-> ##34 (state_q == st_idle))
		else $error("divide did not finish in 34 cycles");
	div_runs_a: assert property (div_go |=> (state_q == st_div) [*8])
		else $error("divide left its loop early");
	div_flags_a: assert property (div_fin |=>
		(flags_q[FLAG_Z] == ((result_q & $past(wmask_q)) == 32'h0)))
		else $error("zero indicator disagrees with quotient");
	extract_val_a: assert property (go && op_w == op_extract |=>
		result_q == $past(extract_val) && (result_q & ~$past(lmask)) == 32'h0)
		else $error("extract result not zero-filled field");
	insert_keep_a: assert property (go && op_w == op_insert |=>
		((result_q ^ $past(dst_q)) & ~$past(fmask)) == 32'h0)
		else $error("insert disturbed bits outside the field");
	jump_pc_a: assert property (go && op_w == op_jump |=>
		pc_q == ($past(cond_hit) ? $past(dst_q) : $past(pc_q)))
		else $error("jump loaded the wrong pc");
	branch_pc_a: assert property (go && op_w == op_branch |=>
		pc_q == $past(pc_q) + ($past(cond_hit) ? $past(br_disp) : 32'h0))
		else $error("branch moved the pc wrongly");
	jump_flags_a: assert property
		(go && (op_w == op_jump || op_w == op_branch) |=> $stable(flags_q))
		else $error("jump changed an indicator");
	apb_answer_a: assert property (setup |=> pready_q ##1 !pready_q || setup)
		else $error("access phase not answered in one cycle");

	div_done_c: cover property (div_fin);
	div_zero_c: cover property (div_zero);
	insert_c: cover property (go && op_w == op_insert);
	jump_taken_c: cover property (go && op_w == op_jump && cond_hit);
endmodule : exec_slice

`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the execution slice, driven as an APB master.
// Assumes one wait-free APB slave and a single 250 MHz clock.
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import exec_slice_pkg::*;

	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata;
	logic [31:0] rd;
	logic err;
	int num_errors, samples_checked;

	exec_slice exec_slice_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr)
	);

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic chk(input string name, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			$display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
			num_errors++;
		end
	endtask : chk

	// Request held until pready is sampled high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) num_errors++;
	endtask : apb

	task automatic rdc(input logic [7:0] a, input logic [31:0] e,
			input string name);
		apb(1'b0, a, 32'h0);
		chk(name, rd, e);
		chk("read error", {31'h0, err}, 32'h0);
	endtask : rdc

	// Poll until the divider is idle; running out counts as a mismatch
	task automatic wait_idle;
		int n;
		n = 0;
		do begin
			apb(1'b0, STATUS_OFS, 32'h0);
			n++;
		end while (rd[ST_BUSY] !== 1'b0 && n < 40);
		if (rd[ST_BUSY] !== 1'b0) num_errors++;
	endtask : wait_idle

	task automatic div_case(input logic [3:0] op,
			input logic [31:0] s1, s2, dv, q, f);
		apb(1'b1, SRC1_OFS, s1);
		apb(1'b1, SRC2_OFS, s2);
		apb(1'b1, DST_OFS, dv);
		apb(1'b1, CMD_OFS, {28'h0, op});
		wait_idle;
		rdc(RESULT_OFS, q, "quotient");
		rdc(FLAGS_OFS, f, "divide flags");
		rdc(SRC1_OFS, s1, "divisor kept");
		rdc(SRC2_OFS, s2, "dividend kept");
	endtask : div_case

	// Zero divisor sets the sticky flag; a command while busy is refused
	task automatic div_guard;
		apb(1'b1, SRC1_OFS, 32'h0);
		apb(1'b1, CMD_OFS, 32'h3);
		chk("zero divisor taken", {31'h0, err}, 32'h0);
		rdc(STATUS_OFS, 32'h2, "divz set");
		rdc(RESULT_OFS, 32'hffffffdf, "no result on zero");
		apb(1'b1, STATUS_OFS, 32'h2);
		rdc(STATUS_OFS, 32'h0, "divz clear");
		apb(1'b1, SRC1_OFS, 32'h3);
		apb(1'b1, CMD_OFS, 32'h3);
		apb(1'b1, CMD_OFS, 32'h1);
		chk("cmd while busy", {31'h0, err}, 32'h1);
		wait_idle;
		rdc(RESULT_OFS, 32'h21, "word quotient");
	endtask : div_guard

	task automatic fld(input logic [31:0] fw, s2, dv, op, e);
		apb(1'b1, FIELD_OFS, fw);
		apb(1'b1, SRC2_OFS, s2);
		apb(1'b1, DST_OFS, dv);
		apb(1'b1, CMD_OFS, op);
		rdc(RESULT_OFS, e, "field result");
	endtask : fld

	function automatic bit taken(input logic [3:0] c, input logic [3:0] f);
		logic n, z, v, cy;
		logic [15:0] t;
		n = f[FLAG_N];
		z = f[FLAG_Z];
		v = f[FLAG_V];
		cy = f[FLAG_C];
		t = {~cy, ~(cy | z), cy | z, cy, ~(n ^ v), ~((n ^ v) | z),
			(n ^ v) | z, n ^ v, ~z, z, ~n, n, n | z, ~(n | z), ~z, z};
		return t[c];
	endfunction : taken

	// Every test against every indicator pattern
	task automatic jumps;
		for (int fi = 0; fi < 16; fi++) begin
			for (int ci = 0; ci < 16; ci++) begin
				apb(1'b1, FLAGS_OFS, 32'(fi));
				apb(1'b1, PC_OFS, 32'h100);
				apb(1'b1, DST_OFS, 32'h2000);
				apb(1'b1, CMD_OFS, 32'((ci << 8) | 6));
				rdc(PC_OFS, taken(4'(ci), 4'(fi)) ? 32'h2000 : 32'h100,
					"jump pc");
				rdc(FLAGS_OFS, 32'(fi), "jump flags");
			end
		end
	endtask : jumps

	// Extreme displacements both ways, then a branch not taken
	task automatic branches;
		apb(1'b1, FLAGS_OFS, 32'h4);
		apb(1'b1, PC_OFS, 32'h1000);
		apb(1'b1, DST_OFS, 32'h80);
		apb(1'b1, CMD_OFS, 32'h7);
		rdc(PC_OFS, 32'h0f00, "branch back");
		apb(1'b1, DST_OFS, 32'h7f);
		apb(1'b1, CMD_OFS, 32'h7);
		rdc(PC_OFS, 32'h0ffe, "branch fwd");
		rdc(STATUS_OFS, 32'h4, "taken set");
		apb(1'b1, CMD_OFS, 32'h107);
		rdc(PC_OFS, 32'h0ffe, "branch idle");
		rdc(STATUS_OFS, 32'h0, "taken clear");
		rdc(FLAGS_OFS, 32'h4, "branch flags");
	endtask : branches

	task automatic refusals;
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped", {31'h0, err}, 32'h1);
		apb(1'b1, RESULT_OFS, 32'h55);
		chk("result ro", {31'h0, err}, 32'h1);
		apb(1'b1, CMD_OFS, 32'h0);
		chk("op zero", {31'h0, err}, 32'h1);
		apb(1'b1, CMD_OFS, 32'h8);
		chk("op eight", {31'h0, err}, 32'h1);
	endtask : refusals

	task end_sim;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim

	initial begin
		#200000;
		num_errors++;
		end_sim;
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		div_case(4'h1, 32'h7, 32'h9c, 32'h12345600, 32'h123456f2, 32'h8);
		div_case(4'h2, 32'h7, 32'h5, 32'habcd1111, 32'habcd0000, 32'h4);
		div_case(4'h3, 32'h3, 32'h64, 32'h0, 32'h21, 32'h0);
		div_case(4'h3, 32'hfffffffd, 32'h64, 32'h0, 32'hffffffdf, 32'h8);
		div_guard;
		fld(32'h0804, 32'hdeadbeef, 32'h0, 32'h4, 32'hee);
		fld(32'h081c, 32'hdeadbeef, 32'h0, 32'h4, 32'hd);
		fld(32'h0408, 32'h12345, 32'hffffffff, 32'h5, 32'hfffff5ff);
		jumps;
		branches;
		refusals;
		end_sim;
	end
endmodule : tb_top

`default_nettype wire
